// ### rtl/scp_config_power_regs.sv
// Serial port configuration and per-channel power mode registers.
`timescale 1ns/1ps
module scp_config_power_regs #(
   parameter int NCH = scp_pkg::NUM_CHANNELS,
   parameter int BOOT_CYCLES = scp_pkg::BOOT_CYCLES
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // Serial pins
   input wire logic sclkPin,
   input wire logic csPin_b,
   input wire logic sdioIn,
   output logic sdioOut,
   output logic sdioOe,
   // Channel select from the channel index register
   input wire logic [NCH-1:0] chanSel,
   // Datapath controls
   output logic dpSoftReset,
   output logic [NCH-1:0] dpClockEn,
   output logic [NCH-1:0] dpHoldReset,
   output logic [NCH-1:0] linkOutEn,
   // Recovery status
   output logic bootBusy
);

   // ------------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------------
   // The pins are sampled on the core clock, so the serial clock must
   // stay well below one eighth of it for clean edge detection.
   logic [1:0] sclkSync_r;
   logic [1:0] csSync_r;
   logic [1:0] sdiSync_r;
   logic sclkDly_r;

   always_ff @(posedge clock)
   begin
      if (!rst_b)
      begin
         sclkSync_r <= 2'h0;
         csSync_r <= 2'h3;
         sdiSync_r <= 2'h0;
         sclkDly_r <= 1'b0;
      end
      else
      begin
         sclkSync_r <= {sclkSync_r[0], sclkPin};
         csSync_r <= {csSync_r[0], csPin_b};
         sdiSync_r <= {sdiSync_r[0], sdioIn};
         sclkDly_r <= sclkSync_r[1];
      end
   end

   wire sclkRise = sclkSync_r[1] && !sclkDly_r;
   wire sclkFall = !sclkSync_r[1] && sclkDly_r;
   wire csLow = !csSync_r[1];

   // ------------------------------------------------------------------
   // Serial port
   // ------------------------------------------------------------------
   scp_bus_if bus ();
   logic sdoInt;
   logic sdoEnInt;

   scp_serial_port u_port (
      .clock(clock),
      .rst_b(rst_b),
      .csLow(csLow),
      .sclkRise(sclkRise),
      .sclkFall(sclkFall),
      .sdi(sdiSync_r[1]),
      .sdo(sdoInt),
      .sdoEn(sdoEnInt),
      .bus(bus)
   );

   // ------------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------------
   // unsupported addresses ignored
   wire hitCfgA = bus.addr == scp_pkg::ADDR_PORT_CFG_A;
   wire hitCfgB = bus.addr == scp_pkg::ADDR_PORT_CFG_B;
   wire hitPwr = bus.addr == scp_pkg::ADDR_CHAN_POWER;
   wire wrCfgA = bus.wrStb && hitCfgA;
   wire wrCfgB = bus.wrStb && hitCfgB;
   wire wrPwr = bus.wrStb && hitPwr;

   wire softReq = wrCfgA && (bus.wdata[scp_pkg::CFGA_SOFT_RST] ||
                             bus.wdata[scp_pkg::CFGA_SOFT_RST_MIR]);
   wire dpReq = wrCfgB && bus.wdata[scp_pkg::CFGB_DP_SOFT_RST];

   // ------------------------------------------------------------------
   // Configuration register
   // ------------------------------------------------------------------
   logic lsbFirst_r;
   logic ascend_r;
   logic softRst_r;

   always_ff @(posedge clock)
   begin
      if (!rst_b)
         softRst_r <= 1'b0;
      else
         softRst_r <= softReq;
   end

   always_ff @(posedge clock)
   begin
      if (!rst_b || softRst_r)
      begin
         lsbFirst_r <= scp_pkg::RESET_LSB_FIRST;
         ascend_r <= scp_pkg::RESET_ASCEND;
      end
      else if (wrCfgA && !softReq)
      begin
         lsbFirst_r <= bus.wdata[scp_pkg::CFGA_LSB_FIRST] ||
                       bus.wdata[scp_pkg::CFGA_LSB_FIRST_MIR];
         ascend_r <= bus.wdata[scp_pkg::CFGA_ASCEND] ||
                     bus.wdata[scp_pkg::CFGA_ASCEND_MIR];
      end
   end

   assign bus.lsbFirst = lsbFirst_r;
   assign bus.ascend = ascend_r;
   assign bus.portReset = softRst_r;

   // ------------------------------------------------------------------
   // Per-channel power mode
   // ------------------------------------------------------------------
   logic [1:0] pwrMode_r [NCH];
   logic [NCH-1:0] clkEn_r;
   logic [NCH-1:0] hold_r;
   logic [NCH-1:0] link_r;
   logic dpPulse_r;

   always_ff @(posedge clock)
   begin
      if (!rst_b || softRst_r)
         dpPulse_r <= 1'b0;
      else
         dpPulse_r <= dpReq;
   end

   genvar ch;
   generate
      for (ch = 0; ch < NCH; ch++)
      begin : g_chan
         wire [1:0] mode = pwrMode_r[ch];
         always_ff @(posedge clock)
         begin
            if (!rst_b || softRst_r)
               pwrMode_r[ch] <= scp_pkg::RESET_PWR_MODE;
            else if (wrPwr && chanSel[ch])
               pwrMode_r[ch] <= bus.wdata[scp_pkg::PWR_MODE_LSB +: 2];
         end
         always_ff @(posedge clock)
         begin
            if (!rst_b)
            begin
               clkEn_r[ch] <= 1'b1;
               hold_r[ch] <= 1'b0;
               link_r[ch] <= 1'b1;
            end
            else
            begin
               clkEn_r[ch] <= mode != scp_pkg::PWR_STANDBY &&
                              mode != scp_pkg::PWR_DOWN;
               hold_r[ch] <= mode == scp_pkg::PWR_DOWN || dpReq;
               link_r[ch] <= mode != scp_pkg::PWR_DOWN;
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------------
   // Readback
   // ------------------------------------------------------------------
   // Self-clearing bits always read as zero; with both channels selected
   // the lowest selected channel answers.
   wire rdCh = (NCH > 1) && !chanSel[0] && chanSel[1];
   wire [7:0] cfgAByte = {1'b0, lsbFirst_r, ascend_r, 2'h0, ascend_r,
                          lsbFirst_r, 1'b0};
   wire [7:0] pwrByte = {6'h00, pwrMode_r[rdCh]};
   assign bus.rdata = hitCfgA ? cfgAByte :
                      hitCfgB ? scp_pkg::RESET_BYTE :
                      hitPwr ? pwrByte : scp_pkg::RESET_BYTE;

   // ------------------------------------------------------------------
   // Recovery timer
   // ------------------------------------------------------------------
   // recovery window flag
   localparam int BCW = $clog2(BOOT_CYCLES + 1);
   logic [BCW-1:0] bootCnt_r;
   logic busy_r;

   always_ff @(posedge clock)
   begin
      if (!rst_b)
      begin
         bootCnt_r <= '0;
         busy_r <= 1'b0;
      end
      else if (softRst_r)
      begin
         bootCnt_r <= BCW'(BOOT_CYCLES - 1);
         busy_r <= 1'b1;
      end
      else if (bootCnt_r != '0)
         bootCnt_r <= bootCnt_r - BCW'(1);
      else
         busy_r <= 1'b0;
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   assign sdioOut = sdoInt;
   assign sdioOe = sdoEnInt;
   assign dpSoftReset = dpPulse_r;
   assign dpClockEn = clkEn_r;
   assign dpHoldReset = hold_r;
   assign linkOutEn = link_r;
   assign bootBusy = busy_r;

endmodule : scp_config_power_regs

// ### rtl/scp_pkg.sv
// Constants shared by the serial configuration and power register block.
package scp_pkg;

   // ------------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------------
   localparam logic [14:0] ADDR_PORT_CFG_A = 15'h0000;
   localparam logic [14:0] ADDR_PORT_CFG_B = 15'h0001;
   localparam logic [14:0] ADDR_CHAN_POWER = 15'h0002;

   // ------------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------------
   localparam int CFGA_SOFT_RST = 0;
   localparam int CFGA_LSB_FIRST = 1;
   localparam int CFGA_ASCEND = 2;
   localparam int CFGA_ASCEND_MIR = 5;
   localparam int CFGA_LSB_FIRST_MIR = 6;
   localparam int CFGA_SOFT_RST_MIR = 7;
   localparam int CFGB_DP_SOFT_RST = 1;
   localparam int PWR_MODE_LSB = 0;

   // ------------------------------------------------------------------
   // Reset values and encodings
   // ------------------------------------------------------------------
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic RESET_LSB_FIRST = 1'b0;
   localparam logic RESET_ASCEND = 1'b0;
   localparam logic [1:0] PWR_NORMAL = 2'h0;
   localparam logic [1:0] PWR_STANDBY = 2'h2;
   localparam logic [1:0] PWR_DOWN = 2'h3;
   localparam logic [1:0] RESET_PWR_MODE = PWR_NORMAL;

   // ------------------------------------------------------------------
   // Frame layout and timing
   // ------------------------------------------------------------------
   localparam int INSTR_BITS = 16;
   localparam int NUM_CHANNELS = 2;
   localparam int CLOCK_MHZ = 250;
   localparam int BOOT_TIME_MS = 5;
   localparam int BOOT_CYCLES = BOOT_TIME_MS * CLOCK_MHZ * 1000;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_INSTR,
      ST_DATA,
      ST_DRAIN
   } scp_state_t;

endpackage : scp_pkg

// ### rtl/scp_bus_if.sv
// Link between the serial shifter and the register file.
`timescale 1ns/1ps
interface scp_bus_if;
   logic wrStb;
   logic [14:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic lsbFirst;
   logic ascend;
   logic portReset;

   modport port (
      output wrStb,
      output addr,
      output wdata,
      input rdata,
      input lsbFirst,
      input ascend,
      input portReset
   );

   modport regs (
      input wrStb,
      input addr,
      input wdata,
      output rdata,
      output lsbFirst,
      output ascend,
      output portReset
   );
endinterface : scp_bus_if

// ### rtl/scp_serial_port.sv
// Three-wire serial frame shifter, oversampled on the system clock.
`timescale 1ns/1ps
module scp_serial_port (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // Synchronised pin levels and edges
   input wire logic csLow,
   input wire logic sclkRise,
   input wire logic sclkFall,
   input wire logic sdi,
   // Data output pin
   output logic sdo,
   output logic sdoEn,
   // Register side
   scp_bus_if.port bus
);

   // ------------------------------------------------------------------
   // Shift path
   // ------------------------------------------------------------------
   scp_pkg::scp_state_t state_r;
   logic [15:0] shift_r;
   logic [3:0] bitCnt_r;
   logic isRead_r;
   logic [14:0] addr_r;
   logic [7:0] outByte_r;
   logic loadPend_r;
   logic wrStb_r;
   logic stepPend_r;
   logic [7:0] wdata_r;

   wire [15:0] shiftNxt = bus.lsbFirst ? {sdi, shift_r[15:1]} :
                                         {shift_r[14:0], sdi};
   wire [7:0] byteIn = bus.lsbFirst ? shiftNxt[15:8] : shiftNxt[7:0];
   wire instrDone = (state_r == scp_pkg::ST_INSTR) && sclkRise &&
                    (bitCnt_r == 4'(scp_pkg::INSTR_BITS - 1));
   wire byteDone = (state_r == scp_pkg::ST_DATA) && sclkRise &&
                   (bitCnt_r == 4'h7);
   wire [14:0] addrStep = bus.ascend ? addr_r + 15'h0001 :
                                       addr_r - 15'h0001;
   wire [2:0] outIdx = bus.lsbFirst ? bitCnt_r[2:0] : 3'h7 - bitCnt_r[2:0];

   assign bus.wrStb = wrStb_r;
   assign bus.addr = addr_r;
   assign bus.wdata = wdata_r;

   // ------------------------------------------------------------------
   // Frame sequencing
   // ------------------------------------------------------------------
   always_ff @(posedge clock)
   begin
      wrStb_r <= 1'b0;
      stepPend_r <= 1'b0;
      if (!rst_b)
      begin
         state_r <= scp_pkg::ST_IDLE;
         shift_r <= 16'h0000;
         bitCnt_r <= 4'h0;
         isRead_r <= 1'b0;
         addr_r <= 15'h0000;
         wdata_r <= 8'h00;
         loadPend_r <= 1'b0;
      end
      else if (bus.portReset)
      begin
         state_r <= csLow ? scp_pkg::ST_DRAIN : scp_pkg::ST_IDLE;
         bitCnt_r <= 4'h0;
         loadPend_r <= 1'b0;
      end
      else if (!csLow)
      begin
         state_r <= scp_pkg::ST_IDLE;
         bitCnt_r <= 4'h0;
      end
      else
      begin
         case (state_r)
            scp_pkg::ST_IDLE:
            begin
               state_r <= scp_pkg::ST_INSTR;
               bitCnt_r <= 4'h0;
            end
            scp_pkg::ST_INSTR:
               if (sclkRise)
               begin
                  shift_r <= shiftNxt;
                  bitCnt_r <= bitCnt_r + 4'h1;
                  if (instrDone)
                  begin
                     state_r <= scp_pkg::ST_DATA;
                     bitCnt_r <= 4'h0;
                     isRead_r <= shiftNxt[15];
                     addr_r <= shiftNxt[14:0];
                     loadPend_r <= 1'b1;
                  end
               end
            scp_pkg::ST_DATA:
               if (sclkRise)
               begin
                  shift_r <= shiftNxt;
                  bitCnt_r <= byteDone ? 4'h0 : bitCnt_r + 4'h1;
                  if (byteDone)
                  begin
                     stepPend_r <= 1'b1;
                     wrStb_r <= !isRead_r;
                     wdata_r <= byteIn;
                  end
               end
            scp_pkg::ST_DRAIN:
               state_r <= scp_pkg::ST_DRAIN;
            default:
               state_r <= scp_pkg::ST_IDLE;
         endcase
         if (stepPend_r)
         begin
            addr_r <= addrStep;
            loadPend_r <= 1'b1;
         end
         else if (loadPend_r)
            loadPend_r <= 1'b0;
      end
   end

   // The address steps only after the write strobe, so a write lands on
   // the byte's own address; the next read byte is fetched one cycle later.
   always_ff @(posedge clock)
   begin
      if (!rst_b)
         outByte_r <= 8'h00;
      else if (loadPend_r)
         outByte_r <= bus.rdata;
   end

   // ------------------------------------------------------------------
   // Readback drive
   // ------------------------------------------------------------------
   // bit order of readback
   always_ff @(posedge clock)
   begin
      if (!rst_b || !csLow || bus.portReset)
      begin
         sdo <= 1'b0;
         sdoEn <= 1'b0;
      end
      else if (state_r == scp_pkg::ST_DATA && isRead_r && sclkFall)
      begin
         sdo <= outByte_r[outIdx];
         sdoEn <= 1'b1;
      end
   end

endmodule : scp_serial_port

// ### verif/scp_config_power_regs_props.sv
// Port-level assertions for the configuration and power register block.
`timescale 1ns/1ps
module scp_config_power_regs_props #(
   parameter int NCH = scp_pkg::NUM_CHANNELS,
   parameter int BOOT_CYCLES = scp_pkg::BOOT_CYCLES
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // Serial pins
   input wire logic sclkPin,
   input wire logic csPin_b,
   input wire logic sdioIn,
   input wire logic sdioOut,
   input wire logic sdioOe,
   // Channel select and datapath controls
   input wire logic [NCH-1:0] chanSel,
   input wire logic dpSoftReset,
   input wire logic [NCH-1:0] dpClockEn,
   input wire logic [NCH-1:0] dpHoldReset,
   input wire logic [NCH-1:0] linkOutEn,
   input wire logic bootBusy
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);

   // ------------------------------------------------------------------
   // Recovery counter
   // ------------------------------------------------------------------
   // The recovery time is too long for a repetition, so it is counted.
   int busyCnt_r;
   always_ff @(posedge clock)
   begin
      if (!rst_b || !bootBusy)
         busyCnt_r <= 0;
      else
         busyCnt_r <= busyCnt_r + 1;
   end

   // ------------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------------
   // Six cycles of one pin level outlast the two-flop synchroniser.
   sequence s_csIdle;
      csPin_b [*6];
   endsequence
   sequence s_sclkHigh;
      sclkPin [*6];
   endsequence

   property p_busyLen;
      $fell(bootBusy) |-> busyCnt_r == BOOT_CYCLES;
   endproperty
   property p_busyMax;
      busyCnt_r <= BOOT_CYCLES;
   endproperty
   property p_bootFresh;
      $rose(bootBusy) |-> ##[0:2] (&dpClockEn && &linkOutEn);
   endproperty
   property p_dpPulse;
      dpSoftReset |=> !dpSoftReset;
   endproperty
   property p_dpHold;
      dpSoftReset |-> ##[0:1] (&dpHoldReset);
   endproperty
   property p_pwrDown;
      ((~linkOutEn) & (dpClockEn | ~dpHoldReset)) == '0;
   endproperty
   property p_sdoHold;
      s_sclkHigh |-> $stable(sdioOut);
   endproperty
   property p_quiet;
      s_csIdle |=> $stable(linkOutEn) && $stable(dpClockEn);
   endproperty

   a_busyLen: assert property (p_busyLen)
      else $error("recovery busy length wrong");
   a_busyMax: assert property (p_busyMax)
      else $error("recovery busy too long");
   a_bootFresh: assert property (p_bootFresh)
      else $error("power not normal after soft reset");
   a_dpPulse: assert property (p_dpPulse)
      else $error("datapath reset longer than one cycle");
   a_dpHold: assert property (p_dpHold)
      else $error("datapath reset not held on all channels");
   a_pwrDown: assert property (p_pwrDown)
      else $error("link off without clock stop and hold");
   a_sdoHold: assert property (p_sdoHold)
      else $error("read data moved while serial clock high");
   a_quiet: assert property (p_quiet)
      else $error("power outputs moved outside a frame");
endmodule : scp_config_power_regs_props

// ### verif/scp_host_model.sv
// Serial host model that frames transfers on the configuration port.
`timescale 1ns/1ps
module scp_host_model (
   // Clock
   input wire logic clock,
   // Serial pins
   output logic sclk,
   output logic csB,
   output logic dOut,
   output logic dOe,
   input wire logic dIn
);
   initial
   begin
      sclk = 1'b0;
      csB = 1'b1;
      dOut = 1'b0;
      dOe = 1'b0;
   end

   // Each clock phase lasts six cycles, beyond the four the port needs.
   task automatic bitx(input logic b, input logic drv, output logic r);
      dOe <= drv;
      dOut <= b;
      repeat (6) @(posedge clock);
      sclk <= 1'b1;
      r = dIn;
      repeat (6) @(posedge clock);
      sclk <= 1'b0;
   endtask : bitx

   task automatic xfer(input logic rd, input logic [14:0] a, input int nb,
      input logic [15:0] wd, input logic lsb, output logic [15:0] rv);
      logic [15:0] w;
      logic r;
      int k;
      w = {rd, a};
      rv = 16'h0000;
      csB <= 1'b0;
      repeat (6) @(posedge clock);
      for (int i = 0; i < 16; i++)
         bitx(w[lsb ? i : 15 - i], 1'b1, r);
      for (int i = 0; i < 8 * nb; i++)
      begin
         k = 8 * (i / 8) + (lsb ? i % 8 : 7 - i % 8);
         bitx(wd[k], !rd, r);
         rv[k] = r;
      end
      repeat (6) @(posedge clock);
      csB <= 1'b1;
      dOe <= 1'b0;
      repeat (8) @(posedge clock);
   endtask : xfer
endmodule : scp_host_model

// ### verif/tb_scp_config_power_regs.sv
// Self-checking bench for the configuration and power register block.
`timescale 1ns/1ps
module tb_scp_config_power_regs;
   localparam int BOOT = 200;
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   logic [1:0] chanSel = 2'h3;
   logic sclk, csB, hOut, hOe, sdioOut, sdioOe, dpSoftReset, bootBusy;
   logic [1:0] dpClockEn, dpHoldReset, linkOutEn;
   logic [15:0] rv;
   int mismatches = 0;
   int n_compared = 0;
   int cycles = 0;
   int pulses = 0;
   // A released line shows the inverse of the last level, never a hold.
   wire logic sdio = sdioOe ? sdioOut : (hOe ? hOut : ~hOut);

   always #2 clock = ~clock;

   scp_config_power_regs #(.NCH(2), .BOOT_CYCLES(BOOT)) u_dut (
      .clock(clock), .rst_b(rst_b), .sclkPin(sclk), .csPin_b(csB),
      .sdioIn(sdio), .sdioOut(sdioOut), .sdioOe(sdioOe),
      .chanSel(chanSel), .dpSoftReset(dpSoftReset),
      .dpClockEn(dpClockEn), .dpHoldReset(dpHoldReset),
      .linkOutEn(linkOutEn), .bootBusy(bootBusy));

   scp_host_model u_host (.clock(clock), .sclk(sclk), .csB(csB),
      .dOut(hOut), .dOe(hOe), .dIn(sdio));

   always @(posedge clock)
   begin
      cycles++;
      if (dpSoftReset === 1'b1)
         pulses++;
      if (cycles == 40000)
      begin
         mismatches++;
         test_done();
      end
   end

   task automatic test_done;
      if (mismatches == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : test_done

   task automatic check(input string what, input logic [15:0] seen,
      input logic [15:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic wr(input logic [14:0] a, input logic [7:0] d,
      input logic lsb);
      u_host.xfer(1'b0, a, 1, {8'h00, d}, lsb, rv);
   endtask : wr

   task automatic rdc(input string what, input logic [14:0] a, input int nb,
      input logic [15:0] exp, input logic lsb);
      u_host.xfer(1'b1, a, nb, 16'h0000, lsb, rv);
      check(what, rv, exp);
   endtask : rdc

   task automatic pins(input logic [5:0] exp);
      check("pins", {10'h000, dpClockEn, linkOutEn, dpHoldReset},
         {10'h000, exp});
   endtask : pins

   task automatic t_reset;
      rdc("cfgA", 15'h0000, 1, 16'h0000, 1'b0);
      rdc("cfgB", 15'h0001, 1, 16'h0000, 1'b0);
      rdc("power", 15'h0002, 1, 16'h0000, 1'b0);
      rdc("unmapped", 15'h0003, 1, 16'h0000, 1'b0);
      pins(6'h3C);
   endtask : t_reset

   task automatic t_order;
      for (int i = 0; i < 2; i++)
      begin
         wr(15'h0000, 8'h01 << (i ? 6 : 1), 1'b0);
         rdc("lsbFirst", 15'h0000, 1, 16'h0042, 1'b1);
         wr(15'h0000, 8'h00, 1'b1);
         rdc("msbFirst", 15'h0000, 1, 16'h0000, 1'b0);
      end
   endtask : t_order

   task automatic t_dir;
      wr(15'h0002, 8'h02, 1'b0);
      rdc("descend", 15'h0001, 2, 16'h0000, 1'b0);
      for (int i = 0; i < 2; i++)
      begin
         wr(15'h0000, 8'h01 << (i ? 5 : 2), 1'b0);
         rdc("ascend", 15'h0001, 2, 16'h0200, 1'b0);
         rdc("cfgA", 15'h0000, 1, 16'h0024, 1'b0);
         wr(15'h0000, 8'h00, 1'b0);
      end
   endtask : t_dir

   task automatic t_chan;
      logic [1:0] sel [4] = '{2'h1, 2'h2, 2'h0, 2'h3};
      logic [7:0] mode [4] = '{8'h00, 8'h03, 8'h02, 8'h00};
      logic [5:0] exp [4] = '{6'h1C, 6'h16, 6'h16, 6'h3C};
      for (int i = 0; i < 4; i++)
      begin
         chanSel <= sel[i];
         wr(15'h0002, mode[i], 1'b0);
         pins(exp[i]);
         if (sel[i] != 2'h0)
            rdc("mode", 15'h0002, 1, {8'h00, mode[i]}, 1'b0);
      end
   endtask : t_chan

   task automatic t_dp;
      pulses = 0;
      wr(15'h0001, 8'h02, 1'b0);
      check("dpPulses", pulses[15:0], 16'h0001);
      rdc("cfgB", 15'h0001, 1, 16'h0000, 1'b0);
      pins(6'h3C);
   endtask : t_dp

   task automatic t_soft;
      int n;
      for (int i = 0; i < 2; i++)
      begin
         wr(15'h0002, 8'h03, 1'b0);
         wr(15'h0000, 8'h24, 1'b0);
         wr(15'h0000, i ? 8'h80 : 8'h01, 1'b0);
         check("busy", {15'h0000, bootBusy}, 16'h0001);
         n = 0;
         while (bootBusy !== 1'b0 && n < 400)
         begin
            @(posedge clock);
            n++;
         end
         check("busyEnd", {15'h0000, bootBusy}, 16'h0000);
         rdc("cfgA", 15'h0000, 1, 16'h0000, 1'b0);
         rdc("power", 15'h0002, 1, 16'h0000, 1'b0);
         pins(6'h3C);
      end
   endtask : t_soft

   initial
   begin
      repeat (16) @(posedge clock);
      rst_b <= 1'b1;
      repeat (4) @(posedge clock);
      t_reset();
      t_order();
      t_dir();
      t_chan();
      t_dp();
      t_soft();
      test_done();
   end
endmodule : tb_scp_config_power_regs

bind scp_config_power_regs scp_config_power_regs_props #(
   .NCH(NCH), .BOOT_CYCLES(BOOT_CYCLES)) u_props (
   .clock(clock), .rst_b(rst_b), .sclkPin(sclkPin), .csPin_b(csPin_b),
   .sdioIn(sdioIn), .sdioOut(sdioOut), .sdioOe(sdioOe),
   .chanSel(chanSel), .dpSoftReset(dpSoftReset),
   .dpClockEn(dpClockEn), .dpHoldReset(dpHoldReset),
   .linkOutEn(linkOutEn), .bootBusy(bootBusy));
